// ### dozc_cfg.svh
// Constants for the displacement output and zeroing controller.
`ifndef DOZC_CFG_SVH
`define DOZC_CFG_SVH
`define DOZC_CLK_HZ 100000000
`define DOZC_MEAS_HZ 1000
`define DOZC_INIT_MS 10000
`define DOZC_LOCK_MS 300000
`define DOZC_REJECT_MS 2000
`define DOZC_FLASH_HZ 8
`define DOZC_LASER_MS 1
`define DOZC_DEBOUNCE_MS 2
`define DOZC_BAUD 230400
`define DOZC_AVG_LEN 64
`define DOZC_AVG_SHIFT 6
`define DOZC_MED_LEN 9
`define DOZC_PIPE_DEPTH 3
`define DOZC_CHAR_DASH 8'h2d
`define DOZC_CHAR_GT 8'h3e
`define DOZC_ADDR_CTRL 12'h000
`define DOZC_ADDR_CMD 12'h004
`define DOZC_ADDR_STATUS 12'h008
`define DOZC_ADDR_MEAS 12'h00c
`define DOZC_ADDR_ZERO 12'h010
`define DOZC_ADDR_SAVED 12'h014
`define DOZC_CTRL_RESET 8'h48
`define DOZC_CMD_SAVE 0
`define DOZC_CMD_UNLOCK 1
`define DOZC_CMD_ZERO_CLR 2
`define DOZC_MID_SCALE 16'h8000
`endif

// ### dozc_pkg.sv
// Types shared by the displacement output and zeroing controller.
package dozc_pkg;
    typedef enum logic [1:0] {
        QUAL_BALANCED = 2'b00,
        QUAL_DYNAMIC = 2'b01,
        QUAL_NONE = 2'b10,
        QUAL_SPARE = 2'b11
    } dozc_quality_type;

    typedef enum logic [1:0] {
        MF_INACTIVE = 2'b00,
        MF_ZERO = 2'b01,
        MF_TRIGGER = 2'b10,
        MF_TEACH = 2'b11
    } dozc_mf_type;

    typedef struct packed {
        logic keyEnable;
        logic mfActiveHigh;
        logic [1:0] spare;
        dozc_mf_type mfFunc;
        dozc_quality_type quality;
    } dozc_ctrl_type;

    typedef struct packed {
        logic redOn;
        logic greenOn;
        logic outOn;
    } dozc_led_type;

    typedef enum logic [1:0] {
        PH_INIT = 2'b00,
        PH_PROMPT = 2'b01,
        PH_RUN = 2'b10
    } dozc_phase_type;
endpackage : dozc_pkg

// ### dozc_ctrl.sv
// Measurement pipeline, filtering, zeroing and key handling of the sensor.
//
// Behaviour
// - Light all LEDs during power-up initialization.
// - Send "->" on serial after initialization.
// - Initialization ends within ten seconds.
// - During initialization only key reset/bootloader.
// - Laser on only while enable grounded.
// - Value output three cycles after acquisition.
// - Next value follows one cycle later.
// - Quality picks mean64, median9 or none.
// - Settings volatile unless explicitly saved.
// - Multifunction input function and active level.
// - Key function inactive locks the key.
// - Zeroing maps current value to mid-scale.
// - Later readings are offsets from zero.
// - Zeroing only with target in range.
// - Offset applies to analog and digital.
// - Key auto-locks after five minutes.
// - Locked key press does nothing.
// - Rejection flashes red 8 Hz two seconds.
// - Key and input both may zero.
// - Open multifunction input reads high.
// - Valid data one millisecond after laser on.
`timescale 1ns/1ps
`include "dozc_cfg.svh"

module dozc_ctrl #(
    parameter int DATA_W = 16,
    parameter int TICK_CYCLES = `DOZC_CLK_HZ / `DOZC_MEAS_HZ,
    parameter int INIT_TICKS = `DOZC_INIT_MS,
    parameter int LOCK_TICKS = `DOZC_LOCK_MS,
    parameter int FLASH_CYCLES = `DOZC_CLK_HZ / (2 * `DOZC_FLASH_HZ),
    parameter int BAUD_CYCLES = `DOZC_CLK_HZ / `DOZC_BAUD
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic nvReset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic laserEnN,
    input wire logic mfIn,
    input wire logic keyN,
    input wire logic [DATA_W-1:0] sampleIn,
    input wire logic targetValid,
    output logic laserOn,
    output logic [DATA_W-1:0] measOut,
    output logic measValid,
    output logic [DATA_W-1:0] analogCode,
    output logic serialTx,
    output dozc_pkg::dozc_led_type leds,
    output logic bootReq
);
    import dozc_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int REJECT_TICKS = `DOZC_REJECT_MS;

    function automatic logic [DATA_W-1:0] median9(
        input logic [`DOZC_MED_LEN*DATA_W-1:0] win
    );
        logic [DATA_W-1:0] res;
        logic [DATA_W-1:0] a;
        logic [DATA_W-1:0] b;
        int lo;
        int eq;
        res = '0;
        for (int i = 0; i < `DOZC_MED_LEN; i++) begin
            lo = 0;
            eq = 0;
            a = win[i*DATA_W +: DATA_W];
            for (int j = 0; j < `DOZC_MED_LEN; j++) begin
                b = win[j*DATA_W +: DATA_W];
                if (b < a) begin
                    lo++;
                end else if (b == a) begin
                    eq++;
                end
            end
            if (lo <= `DOZC_MED_LEN / 2 && lo + eq > `DOZC_MED_LEN / 2) begin
                res = a;
            end
        end
        return res;
    endfunction : median9

    // Measuring-cycle tick: every slower rate except the red flash, which counts clocks, hangs off this enable.
    logic [TW-1:0] tickCnt_reg;
    logic tick;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tickCnt_reg <= '0;
        end else if (tickCnt_reg == TW'(TICK_CYCLES - 1)) begin
            tickCnt_reg <= '0;
        end else begin
            tickCnt_reg <= tickCnt_reg + 1'b1;
        end
    end
    assign tick = (tickCnt_reg == TW'(TICK_CYCLES - 1));

    // Pin synchronizers; the first stage feeds only the second.
    logic [2:0] syncA_reg;
    logic [2:0] syncB_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            syncA_reg <= 3'h7;
            syncB_reg <= 3'h7;
        end else begin
            syncA_reg <= {laserEnN, mfIn, keyN};
            syncB_reg <= syncA_reg;
        end
    end

    // Debounce: a level is accepted once stable for a few ticks.
    // An open input idles high, so the filtered level resets high.
    logic [1:0] debDone_reg;
    logic [1:0] debCnt_reg [2];
    logic mfPrev_reg;
    logic keyPrev_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            debDone_reg <= 2'h3;
            debCnt_reg[0] <= '0;
            debCnt_reg[1] <= '0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (syncB_reg[k] == debDone_reg[k]) begin
                    debCnt_reg[k] <= '0;
                end else if (tick) begin
                    if (debCnt_reg[k] == 2'(`DOZC_DEBOUNCE_MS)) begin
                        debDone_reg[k] <= syncB_reg[k];
                        debCnt_reg[k] <= '0;
                    end else begin
                        debCnt_reg[k] <= debCnt_reg[k] + 1'b1;
                    end
                end
            end
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mfPrev_reg <= 1'b1;
            keyPrev_reg <= 1'b1;
        end else begin
            mfPrev_reg <= debDone_reg[1];
            keyPrev_reg <= debDone_reg[0];
        end
    end

    // Initialization phase counter and prompt.
    dozc_phase_type phase_reg;
    logic [$clog2(INIT_TICKS + 1)-1:0] initCnt_reg;
    logic promptDone;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_reg <= PH_INIT;
            initCnt_reg <= '0;
        end else begin
            unique case (phase_reg)
                PH_INIT: begin
                    if (tick) begin
                        if (initCnt_reg == ($bits(initCnt_reg))'(INIT_TICKS - 1)) begin
                            phase_reg <= PH_PROMPT;
                        end else begin
                            initCnt_reg <= initCnt_reg + 1'b1;
                        end
                    end
                end
                PH_PROMPT: begin
                    if (promptDone) begin
                        phase_reg <= PH_RUN;
                    end
                end
                PH_RUN: begin
                    phase_reg <= PH_RUN;
                end
                default: begin
                    phase_reg <= PH_INIT;
                end
            endcase
        end
    end
    logic running;
    assign running = (phase_reg == PH_RUN);

    // Prompt transmitter: two 8N1 characters, sent once.
    logic [19:0] txShift_reg;
    logic [4:0] txBits_reg;
    logic [$clog2(BAUD_CYCLES + 1)-1:0] baudCnt_reg;
    logic txLoaded_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            txShift_reg <= '1;
            txBits_reg <= '0;
            baudCnt_reg <= '0;
            txLoaded_reg <= 1'b0;
            serialTx <= 1'b1;
        end else if (phase_reg == PH_PROMPT && !txLoaded_reg) begin
            txShift_reg <= {1'b1, `DOZC_CHAR_GT, 1'b0, 1'b1, `DOZC_CHAR_DASH, 1'b0};
            txBits_reg <= 5'd20;
            txLoaded_reg <= 1'b1;
            baudCnt_reg <= '0;
        end else if (txBits_reg != 5'd0) begin
            if (baudCnt_reg == ($bits(baudCnt_reg))'(BAUD_CYCLES - 1)) begin
                baudCnt_reg <= '0;
                serialTx <= txShift_reg[0];
                txShift_reg <= {1'b1, txShift_reg[19:1]};
                txBits_reg <= txBits_reg - 1'b1;
            end else begin
                baudCnt_reg <= baudCnt_reg + 1'b1;
            end
        end
    end
    assign promptDone = txLoaded_reg && txBits_reg == 5'd0;

    // Key presses during initialization only reach the boot path.
    logic keyFall;
    logic mfEdge;
    assign keyFall = keyPrev_reg && !debDone_reg[0];
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bootReq <= 1'b0;
        end else begin
            bootReq <= (phase_reg == PH_INIT) && keyFall;
        end
    end

    // Working and saved settings.  The saved copy survives a
    // supply reset and only clears with its own reset.
    dozc_ctrl_type ctrl_reg;
    dozc_ctrl_type saved_reg;
    logic savedValid_reg;
    logic loadPending_reg;
    logic apbWrite;
    logic apbSetup;
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite && pready && running;
    always_ff @(posedge clk or posedge nvReset) begin
        if (nvReset) begin
            saved_reg <= dozc_ctrl_type'(`DOZC_CTRL_RESET);
            savedValid_reg <= 1'b0;
        end else if (apbWrite && paddr == `DOZC_ADDR_CMD && pwdata[`DOZC_CMD_SAVE]) begin
            saved_reg <= ctrl_reg;
            savedValid_reg <= 1'b1;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= dozc_ctrl_type'(`DOZC_CTRL_RESET);
            loadPending_reg <= 1'b1;
        end else if (loadPending_reg) begin
            if (savedValid_reg) begin
                ctrl_reg <= saved_reg;
            end
            loadPending_reg <= 1'b0;
        end else if (apbWrite && paddr == `DOZC_ADDR_CTRL) begin
            ctrl_reg <= dozc_ctrl_type'(pwdata[7:0]);
        end
    end

    // Multifunction input edge of the chosen active level.
    assign mfEdge = ctrl_reg.mfActiveHigh ? (!mfPrev_reg && debDone_reg[1])
                                          : (mfPrev_reg && !debDone_reg[1]);

    // Automatic key lock after the lock time; software unlocks.
    logic keyLocked_reg;
    logic [$clog2(LOCK_TICKS + 1)-1:0] lockCnt_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            keyLocked_reg <= 1'b0;
            lockCnt_reg <= '0;
        end else if (tick && running && !keyLocked_reg &&
                     lockCnt_reg == ($bits(lockCnt_reg))'(LOCK_TICKS - 1)) begin
            keyLocked_reg <= 1'b1;
        end else if (apbWrite && paddr == `DOZC_ADDR_CMD && pwdata[`DOZC_CMD_UNLOCK]) begin
            keyLocked_reg <= 1'b0;
            lockCnt_reg <= '0;
        end else if (tick && running && !keyLocked_reg) begin
            lockCnt_reg <= lockCnt_reg + 1'b1;
        end
    end

    // Zeroing requests from either source; spacing is the caller's duty.
    logic keyZero;
    logic mfZero;
    logic zeroReq;
    assign keyZero = keyFall && ctrl_reg.keyEnable && !keyLocked_reg;
    assign mfZero = mfEdge && ctrl_reg.mfFunc == MF_ZERO;
    assign zeroReq = running && (keyZero || mfZero);

    // Laser enable and settle time before data counts as correct.
    logic laserSettle_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            laserOn <= 1'b0;
            laserSettle_reg <= 1'b0;
        end else begin
            laserOn <= !syncB_reg[2];
            if (syncB_reg[2]) begin
                laserSettle_reg <= 1'b0;
            end else if (tick && laserOn) begin
                laserSettle_reg <= 1'b1;
            end
        end
    end

    // Three-stage pipeline: acquire, filter, output.
    logic [DATA_W-1:0] acq_reg;
    logic [DATA_W-1:0] filt_reg;
    logic [`DOZC_PIPE_DEPTH-1:0] stageValid_reg;
    logic [`DOZC_AVG_LEN*DATA_W-1:0] hist_reg;
    logic [DATA_W+`DOZC_AVG_SHIFT-1:0] sum_reg;
    logic [DATA_W-1:0] filtNext;
    always_comb begin
        unique case (ctrl_reg.quality)
            QUAL_BALANCED: filtNext = DATA_W'(sum_reg >> `DOZC_AVG_SHIFT);
            QUAL_DYNAMIC: filtNext = median9(hist_reg[`DOZC_MED_LEN*DATA_W-1:0]);
            default: filtNext = acq_reg;
        endcase
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acq_reg <= '0;
            filt_reg <= '0;
            hist_reg <= '0;
            sum_reg <= '0;
            stageValid_reg <= '0;
        end else if (tick) begin
            acq_reg <= sampleIn;
            hist_reg <= {hist_reg[(`DOZC_AVG_LEN-1)*DATA_W-1:0], sampleIn};
            sum_reg <= sum_reg + {{`DOZC_AVG_SHIFT{1'b0}}, sampleIn} -
                       {{`DOZC_AVG_SHIFT{1'b0}},
                        hist_reg[`DOZC_AVG_LEN*DATA_W-1 -: DATA_W]};
            filt_reg <= filtNext;
            stageValid_reg <= {stageValid_reg[`DOZC_PIPE_DEPTH-2:0],
                               running && laserSettle_reg};
        end
    end

    // Zero offset and rejection flash.
    logic [DATA_W-1:0] zeroOff_reg;
    logic zeroActive_reg;
    logic [$clog2(REJECT_TICKS + 1)-1:0] rejCnt_reg;
    logic [$clog2(FLASH_CYCLES + 1)-1:0] flashCnt_reg;
    logic flash_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            zeroOff_reg <= '0;
            zeroActive_reg <= 1'b0;
        end else if (zeroReq && targetValid) begin
            zeroOff_reg <= filt_reg;
            zeroActive_reg <= 1'b1;
        end else if (apbWrite && paddr == `DOZC_ADDR_CMD && pwdata[`DOZC_CMD_ZERO_CLR]) begin
            zeroOff_reg <= '0;
            zeroActive_reg <= 1'b0;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rejCnt_reg <= '0;
        end else if (zeroReq && !targetValid) begin
            rejCnt_reg <= ($bits(rejCnt_reg))'(REJECT_TICKS);
        end else if (tick && rejCnt_reg != '0) begin
            rejCnt_reg <= rejCnt_reg - 1'b1;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flashCnt_reg <= '0;
            flash_reg <= 1'b0;
        end else if (rejCnt_reg == '0) begin
            flashCnt_reg <= '0;
            flash_reg <= 1'b1;
        end else if (flashCnt_reg == ($bits(flashCnt_reg))'(FLASH_CYCLES - 1)) begin
            flashCnt_reg <= '0;
            flash_reg <= !flash_reg;
        end else begin
            flashCnt_reg <= flashCnt_reg + 1'b1;
        end
    end

    // Outputs: the same offset drives digital and analog paths.
    logic [DATA_W-1:0] relVal;
    assign relVal = filt_reg - zeroOff_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            measOut <= '0;
            analogCode <= '0;
            measValid <= 1'b0;
        end else begin
            measValid <= tick && stageValid_reg[`DOZC_PIPE_DEPTH-1];
            if (tick && stageValid_reg[`DOZC_PIPE_DEPTH-1]) begin
                measOut <= relVal;
                analogCode <= zeroActive_reg ? relVal + DATA_W'(`DOZC_MID_SCALE)
                                             : filt_reg;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            leds <= '1;
        end else if (phase_reg == PH_INIT) begin
            leds <= '1;
        end else if (rejCnt_reg != '0) begin
            leds <= {flash_reg, 1'b0, laserOn};
        end else begin
            leds <= {!targetValid, targetValid && laserOn, laserOn};
        end
    end

    // APB slave: one access cycle, data registered in setup.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= apbSetup;
            pslverr <= 1'b0;
            prdata <= '0;
            if (apbSetup) begin
                unique case (paddr)
                    `DOZC_ADDR_CTRL: prdata <= {24'h0, ctrl_reg};
                    `DOZC_ADDR_CMD: prdata <= '0;
                    `DOZC_ADDR_STATUS: prdata <= {25'h0, savedValid_reg,
                        rejCnt_reg != '0, zeroActive_reg, keyLocked_reg,
                        targetValid, laserOn, running};
                    `DOZC_ADDR_MEAS: prdata <= 32'(measOut);
                    `DOZC_ADDR_ZERO: prdata <= 32'(zeroOff_reg);
                    `DOZC_ADDR_SAVED: prdata <= {24'h0, saved_reg};
                    default: pslverr <= 1'b1;
                endcase
                if (pwrite && !running) begin
                    pslverr <= 1'b1;
                end
            end
        end
    end
endmodule : dozc_ctrl

// ### dozc_ctrl_monitor.sv
// Port-level checker for the displacement output and zeroing controller.
`timescale 1ns/1ps
module dozc_ctrl_monitor #(
    parameter int FLASH_CYCLES = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic laserEnN,
    input wire logic laserOn,
    input wire logic measValid,
    input wire logic serialTx,
    input wire dozc_pkg::dozc_led_type leds,
    input wire logic bootReq
);
    import dozc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Saturates at 1000, so with FLASH_CYCLES up to 1000 the first change after a long quiet spell never looks like a fast flash.
    int sinceFlip;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sinceFlip <= 1000;
        end else if ($changed(leds.redOn)) begin
            sinceFlip <= 1;
        end else if (sinceFlip < 1000) begin
            sinceFlip <= sinceFlip + 1;
        end
    end
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready in the cycle after setup");
    a_single_ready: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_init_leds: assert property ($fell(reset) |-> leds == 3'b111)
        else $error("leds not all lit at start of initialization");
    a_prompt_bound: assert property ($fell(reset) |-> ##[1:300] !serialTx)
        else $error("prompt did not start in time");
    a_start_bit: assert property ($fell(serialTx) |=> !serialTx)
        else $error("serial low bit shorter than a bit time");
    a_laser_on: assert property ($fell(laserEnN) |-> ##[1:4] laserOn)
        else $error("laser not switched on");
    a_laser_off: assert property ($rose(laserEnN) |-> ##[1:4] !laserOn)
        else $error("laser not switched off");
    a_value_spacing: assert property (measValid |=> (!measValid)[*8] ##1 !measValid)
        else $error("values closer than one measuring cycle");
    a_settle_wait: assert property ($rose(laserOn) |-> (!measValid)[*8])
        else $error("value issued before laser settled");
    a_flash_hold: assert property ($changed(leds.redOn) |-> sinceFlip >= FLASH_CYCLES)
        else $error("red led toggled too fast");
    a_boot_pulse: assert property (bootReq |=> !bootReq)
        else $error("boot request longer than one cycle");
endmodule : dozc_ctrl_monitor

bind dozc_ctrl dozc_ctrl_monitor #(.FLASH_CYCLES(FLASH_CYCLES)) u_mon (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pready(pready),
    .laserEnN(laserEnN), .laserOn(laserOn), .measValid(measValid), .serialTx(serialTx),
    .leds(leds), .bootReq(bootReq));

// ### dozc_far_side.sv
// Far-side model: switch contacts on the pins and a serial host receiving bytes.
`timescale 1ns/1ps
module dozc_far_side #(
    parameter int BAUD_CYCLES = 2
) (
    input wire logic clk,
    input wire logic serialTx,
    input wire logic keyPress,
    input wire logic mfPress,
    input wire logic laserReq,
    output logic keyN,
    output logic mfIn,
    output logic laserEnN,
    output logic [15:0] rxPair,
    output logic [7:0] rxCount
);
    logic [8:0] sh;
    // Contacts only pull to ground; an open contact reads high through the pull-up.
    assign keyN = !keyPress;
    assign mfIn = !mfPress;
    assign laserEnN = !laserReq;
    // Samples each bit in its middle, eight data bits first-bit-lowest, then the stop bit.
    initial begin
        rxCount = 8'h00;
        rxPair = 16'h0000;
        sh = 9'h000;
        forever begin
            @(negedge serialTx);
            repeat (BAUD_CYCLES / 2) @(posedge clk);
            for (int i = 0; i < 9; i++) begin
                repeat (BAUD_CYCLES) @(posedge clk);
                sh = {serialTx, sh[8:1]};
            end
            rxPair = {rxPair[7:0], sh[7:0]};
            rxCount = rxCount + 8'h01;
        end
    end
endmodule : dozc_far_side

// ### displacement_output_zeroing_ctrl_tb.sv
// Self-checking bench for the displacement output and zeroing controller.
`timescale 1ns/1ps
`include "dozc_cfg.svh"
module displacement_output_zeroing_ctrl_tb;
    import dozc_pkg::*;
    localparam int TK = 10;
    localparam int FL = 4;
    logic clk, reset, nvReset, psel, penable, pwrite, pready, pslverr, err;
    logic laserEnN, mfIn, keyN, targetValid, laserOn, measValid, serialTx, bootReq;
    logic keyPress, mfPress, laserReq, red;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] sampleIn, measOut, analogCode, base, s, rxPair;
    logic [7:0] rxCount;
    dozc_led_type leds;
    int n_fail, n_compared, seed, cycles;
    dozc_ctrl #(.TICK_CYCLES(TK), .INIT_TICKS(3), .LOCK_TICKS(50), .FLASH_CYCLES(FL),
        .BAUD_CYCLES(2)) u_dut (
        .clk(clk), .reset(reset), .nvReset(nvReset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .laserEnN(laserEnN), .mfIn(mfIn), .keyN(keyN),
        .sampleIn(sampleIn), .targetValid(targetValid), .laserOn(laserOn),
        .measOut(measOut), .measValid(measValid), .analogCode(analogCode),
        .serialTx(serialTx), .leds(leds), .bootReq(bootReq));
    dozc_far_side #(.BAUD_CYCLES(2)) u_far (
        .clk(clk), .serialTx(serialTx), .keyPress(keyPress), .mfPress(mfPress),
        .laserReq(laserReq), .keyN(keyN), .mfIn(mfIn), .laserEnN(laserEnN),
        .rxPair(rxPair), .rxCount(rxCount));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 95000) begin
            n_fail++;
            close_out();
        end
    end
    function automatic logic [15:0] rel(input logic [15:0] v, input logic [15:0] z);
        return v - z;
    endfunction : rel
    function automatic logic [15:0] ana(input logic [15:0] v, input logic [15:0] z);
        return v - z + `DOZC_MID_SCALE;
    endfunction : ana
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        chk(pready, 1'b1, "apb answer");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic meas(input int n);
        int t;
        repeat (n) begin
            t = 0;
            do begin
                @(posedge clk);
                t++;
            end while (measValid !== 1'b1 && t < 500);
            chk(measValid, 1'b1, "value pulse");
        end
    endtask : meas
    task automatic press(input bit useKey);
        if (useKey) keyPress <= 1'b1;
        else mfPress <= 1'b1;
        cyc(8 * TK);
        keyPress <= 1'b0;
        mfPress <= 1'b0;
        cyc(1000 * TK);
    endtask : press
    task automatic boot();
        int t;
        reset <= 1'b1;
        cyc(10);
        chk(leds, 3'b111, "init leds");
        reset <= 1'b0;
        apb(1, `DOZC_ADDR_CTRL, 0);
        chk(err, 1'b1, "early write");
        s = rxCount + 8'h02;
        for (t = 0; t < 1000 && rxCount !== s[7:0]; t++) @(posedge clk);
        chk(rxPair, {`DOZC_CHAR_DASH, `DOZC_CHAR_GT}, "prompt");
        cyc(20);
    endtask : boot
    task automatic close_out();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    initial begin
        seed = 68016;
        {cycles, n_fail, n_compared} = '0;
        {reset, nvReset, targetValid} = 3'b111;
        {psel, penable, pwrite, keyPress, mfPress, laserReq} = '0;
        {paddr, pwdata, sampleIn} = '0;
        boot();
        nvReset <= 1'b0;
        apb(0, `DOZC_ADDR_CTRL, 0);
        chk(rd, {24'h0, `DOZC_CTRL_RESET}, "ctrl reset");
        apb(0, 12'h018, 0);
        chk(err, 1'b1, "unmapped");
        cyc(60 * TK);
        apb(0, `DOZC_ADDR_STATUS, 0);
        chk(rd[3], 1'b1, "auto lock");
        apb(1, `DOZC_ADDR_CTRL, 32'h86);
        laserReq <= 1'b1;
        s = $random(seed);
        sampleIn <= s;
        meas(6);
        chk(measOut, s, "raw");
        chk(analogCode, s, "raw analog");
        press(1);
        meas(5);
        chk(measOut, s, "locked key");
        apb(1, `DOZC_ADDR_CMD, 32'h1 << `DOZC_CMD_UNLOCK);
        // First the key, then the input, each with fresh random positions.
        for (int i = 0; i < 2; i++) begin
            base = $random(seed);
            sampleIn <= base;
            meas(5);
            press(i == 0);
            meas(5);
            chk(measOut, 16'h0, "zeroed");
            chk(analogCode, `DOZC_MID_SCALE, "mid");
            s = $random(seed);
            sampleIn <= s;
            meas(5);
            chk(measOut, rel(s, base), "relative");
            chk(analogCode, ana(s, base), "relative analog");
        end
        for (int i = 0; i < 2; i++) begin
            apb(1, `DOZC_ADDR_CTRL, i ? 32'h06 : 32'h82);
            apb(1, `DOZC_ADDR_CMD, 32'h1 << `DOZC_CMD_UNLOCK);
            press(i);
            meas(5);
            chk(measOut, rel(s, base), "ignored");
        end
        for (int i = 0; i < 2; i++) begin
            apb(1, `DOZC_ADDR_CTRL, i ? 32'h84 : 32'h85);
            meas(i ? 70 : 12);
            chk(measOut, rel(s, base), "filtered");
        end
        apb(1, `DOZC_ADDR_CTRL, 32'h86);
        apb(1, `DOZC_ADDR_CMD, 32'h1 << `DOZC_CMD_SAVE);
        for (int i = 0; i < 2; i++) begin
            boot();
            apb(0, `DOZC_ADDR_CTRL, 0);
            chk(rd, 32'h86, "kept settings");
            apb(1, `DOZC_ADDR_CTRL, 32'h85);
        end
        apb(1, `DOZC_ADDR_CMD, 32'h1 << `DOZC_CMD_UNLOCK);
        targetValid <= 1'b0;
        meas(5);
        press(1);
        apb(0, `DOZC_ADDR_STATUS, 0);
        chk(rd[5], 1'b1, "rejecting");
        for (int i = 0; i < 3; i++) begin
            red = leds.redOn;
            cyc(FL);
            chk(leds.redOn, !red, "flash");
        end
        laserReq <= 1'b0;
        cyc(6);
        chk(laserOn, 1'b0, "laser off");
        close_out();
    end
endmodule : displacement_output_zeroing_ctrl_tb
